// File: mission_logger_pkg.sv
/*
  Package of the mission logging engine: memory map, field sizes and state codes.
  Assumes the user includes it before the logger module.
*/
package mission_logger_pkg;
  // ----------------------------------------------------------------
  // Memory map (byte addresses of the serial memory space)
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_START_MINUTES = 16'h0215;
  localparam logic [15:0] ADDR_START_HOURS = 16'h0216;
  localparam logic [15:0] ADDR_START_DATE = 16'h0217;
  localparam logic [15:0] ADDR_START_MONTH = 16'h0218;
  localparam logic [15:0] ADDR_START_YEAR = 16'h0219;
  localparam logic [15:0] ADDR_MISSION_COUNT_LOW = 16'h021a;
  localparam logic [15:0] ADDR_MISSION_COUNT_MID = 16'h021b;
  localparam logic [15:0] ADDR_MISSION_COUNT_HIGH = 16'h021c;
  localparam logic [15:0] ADDR_LIFETIME_COUNT_LOW = 16'h021d;
  localparam logic [15:0] ADDR_LIFETIME_COUNT_MID = 16'h021e;
  localparam logic [15:0] ADDR_LIFETIME_COUNT_HIGH = 16'h021f;
  localparam logic [15:0] ADDR_ALARM_BASE = 16'h0220;
  localparam logic [15:0] ADDR_ALARM_LAST = 16'h027f;
  localparam logic [15:0] ADDR_HIGH_ALARM_BASE = 16'h0250;
  localparam logic [15:0] ADDR_HIST_BASE = 16'h0800;
  localparam logic [15:0] ADDR_HIST_LAST = 16'h087d;
  localparam logic [15:0] ADDR_LOG_BASE = 16'h1000;
  localparam logic [15:0] ADDR_LOG_LAST = 16'h17ff;

  // ----------------------------------------------------------------
  // Sizes and limits
  // ----------------------------------------------------------------
  localparam int LOG_DEPTH = 2048;
  localparam int HIST_BINS = 63;
  localparam int ALARM_ENTRIES = 12;
  localparam int ALARM_BYTES = 4;
  localparam logic [7:0] READING_MAX = 8'hfa;
  localparam logic [15:0] BIN_MAX = 16'hffff;
  localparam logic [7:0] DURATION_MAX = 8'hff;
  localparam logic [23:0] COUNT_ZERO = 24'h000000;

  // ----------------------------------------------------------------
  // Mission sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_CONV = 2'b10,
    ST_GAP = 2'b11
  } mission_state_t;
endpackage

// File: mission_temperature_logger.sv
/*
  Mission logging engine of a self-timed temperature logger: start timestamp,
  sample counters, data log, histogram and alarm records, with a byte read port.
  Assumes conversion results and minute ticks are synchronous one-cycle pulses.
*/
// Operation
// - First conversion stores BCD start time/date
// - Later conversions every sample-rate minute boundaries
// - 24-bit mission sample count, low byte first
// - Memory clear zeroes mission sample count
// - 24-bit lifetime count, never cleared
// - Readings written sequentially from log base
// - No wrap: stop logging after 2048
// - Wrap: 2049th sample overwrites log base
// - 63 16-bit bins, low byte lower
// - Each sample bumps bin reading>>2
// - Clamp readings to 00h..FAh first
// - Full bin saturates and holds
// - Histogram updated only during mission
// - Threshold reached raises high/low alarm flag
// - Twelve low then twelve high entries
// - Episode start stores count and duration
// - Duration 255 opens a fresh entry
// - In-band freezes duration; next uses new entry
// - Low and high records run independently
// - Each sample bumps mission and lifetime counts
// - One bit selects log wrap
// - After delay, next minute starts first sample
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------------
// Alarm record keeper for one direction
// ------------------------------------------------------------------
module alarm_recorder #(
  parameter int ENTRIES = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic sample_ev,
  input wire logic out_band,
  input wire logic [23:0] count,
  // Read side
  input wire logic [5:0] rd_idx,
  output logic [7:0] rd_byte
);
  logic [23:0] stamp_q [ENTRIES]; // Timestamps
  logic [7:0] dur_q [ENTRIES]; // Durations
  logic [3:0] ptr_q; // Next unused entry
  logic open_q; // Episode running in entry ptr_q-1
  logic [3:0] last; // Entry of the running episode
  logic [3:0] rd_entry;

  assign last = ptr_q - 4'h1;
  assign rd_entry = rd_idx[5:2];

  // Episode tracking; a reading back in band freezes the entry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= 4'h0;
      open_q <= 1'b0;
      for (int i = 0; i < ENTRIES; i++) begin
        stamp_q[i] <= 24'h000000;
        dur_q[i] <= 8'h00;
      end
    end else if (clear) begin
      ptr_q <= 4'h0;
      open_q <= 1'b0;
      for (int i = 0; i < ENTRIES; i++) begin
        stamp_q[i] <= 24'h000000;
        dur_q[i] <= 8'h00;
      end
    end else if (sample_ev) begin
      if (!out_band) begin
        open_q <= 1'b0;
      end else if (open_q && dur_q[last] != mission_logger_pkg::DURATION_MAX) begin
        dur_q[last] <= dur_q[last] + 8'h01;
      end else if (ptr_q < 4'(ENTRIES)) begin
        // New episode, or duration exhausted: open next entry
        stamp_q[ptr_q] <= count;
        dur_q[ptr_q] <= 8'h01;
        ptr_q <= ptr_q + 4'h1;
        open_q <= 1'b1;
      end else begin
        open_q <= 1'b0;
      end
    end
  end

  // Byte read: timestamp low, mid, high, then duration
  always_comb begin
    rd_byte = 8'h00;
    if (rd_entry < 4'(ENTRIES)) begin
      case (rd_idx[1:0])
        2'b00: rd_byte = stamp_q[rd_entry][7:0];
        2'b01: rd_byte = stamp_q[rd_entry][15:8];
        2'b10: rd_byte = stamp_q[rd_entry][23:16];
        default: rd_byte = dur_q[rd_entry];
      endcase
    end
  end
endmodule // alarm_recorder

// ------------------------------------------------------------------
// Top: mission logging engine
// ------------------------------------------------------------------
module mission_temperature_logger #(
  parameter int LOG_DEPTH = mission_logger_pkg::LOG_DEPTH,
  parameter int HIST_BINS = mission_logger_pkg::HIST_BINS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Mission control
  input wire logic mission_start,
  input wire logic mission_stop,
  input wire logic mission_arm_inhibit,
  input wire logic [7:0] sample_rate,
  input wire logic [15:0] start_delay,
  input wire logic log_wrap_enable,
  input wire logic memory_clear,
  input wire logic [7:0] low_threshold,
  input wire logic [7:0] high_threshold,
  input wire logic low_flag_clear,
  input wire logic high_flag_clear,
  // Real-time clock
  input wire logic minute_tick,
  input wire logic [7:0] rtc_minutes,
  input wire logic [7:0] rtc_hours,
  input wire logic [7:0] rtc_date,
  input wire logic [7:0] rtc_month,
  input wire logic [7:0] rtc_year,
  // Converter
  output logic conv_request,
  input wire logic conv_valid,
  input wire logic [7:0] conv_data,
  // Status
  output logic mission_active,
  output logic low_alarm_flag,
  output logic high_alarm_flag,
  // Read port
  input wire logic rd_en,
  input wire logic [15:0] rd_addr,
  output logic rd_valid,
  output logic [7:0] rd_data
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q, rst_sync_q;
  logic rst_n_int; // Synchronised reset used by the design

  // Two stages so release never lands near a clock edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n_int = rst_sync_q;

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  mission_logger_pkg::mission_state_t state_q;
  logic [15:0] delay_q; // Minutes still to wait
  logic [7:0] rate_q; // Latched sample rate
  logic [7:0] gap_q; // Minutes since last sample
  logic wrap_q; // Latched wrap selection
  logic [7:0] ts_q [5]; // Start time and date, BCD
  logic [23:0] mission_count_q;
  logic [23:0] lifetime_count_q;
  logic [10:0] log_ptr_q; // Next data log slot
  logic log_full_q; // Log filled without wrap
  logic [7:0] log_mem [LOG_DEPTH];
  logic [15:0] hist_q [HIST_BINS];
  logic sample_ev; // Mission conversion result arrives
  logic [7:0] clamped;
  logic [5:0] bin;
  logic [23:0] count_next;
  logic out_low, out_high;
  logic [7:0] low_byte, high_byte;

  // A stop in the answer cycle drops the result, as the sequencer does
  assign sample_ev = (state_q == mission_logger_pkg::ST_CONV) && conv_valid && !mission_stop;
  assign clamped = (conv_data > mission_logger_pkg::READING_MAX) ?
                   mission_logger_pkg::READING_MAX : conv_data;
  assign bin = clamped[7:2];
  assign count_next = mission_count_q + 24'h000001;
  assign out_low = conv_data <= low_threshold;
  assign out_high = conv_data >= high_threshold;

  // ----------------------------------------------------------------
  // Mission sequencer
  // ----------------------------------------------------------------
  // A stop always wins so a stop during a conversion drops its result
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state_q <= mission_logger_pkg::ST_IDLE;
      delay_q <= 16'h0000;
      rate_q <= 8'h00;
      gap_q <= 8'h00;
      wrap_q <= 1'b0;
      conv_request <= 1'b0;
    end else begin
      conv_request <= 1'b0;
      if (mission_stop) begin
        state_q <= mission_logger_pkg::ST_IDLE;
      end else begin
        case (state_q)
          mission_logger_pkg::ST_IDLE: begin
            // Start only when armed and with a nonzero rate
            if (mission_start && !mission_arm_inhibit && sample_rate != 8'h00) begin
              rate_q <= sample_rate;
              delay_q <= start_delay;
              wrap_q <= log_wrap_enable;
              state_q <= mission_logger_pkg::ST_DELAY;
            end
          end
          mission_logger_pkg::ST_DELAY: begin
            if (minute_tick) begin
              if (delay_q != 16'h0000) begin
                delay_q <= delay_q - 16'h0001;
              end else begin
                conv_request <= 1'b1;
                state_q <= mission_logger_pkg::ST_CONV;
              end
            end
          end
          mission_logger_pkg::ST_CONV: begin
            if (conv_valid) begin
              gap_q <= 8'h01;
              state_q <= mission_logger_pkg::ST_GAP;
            end
          end
          mission_logger_pkg::ST_GAP: begin
            if (minute_tick) begin
              if (gap_q == rate_q) begin
                conv_request <= 1'b1;
                state_q <= mission_logger_pkg::ST_CONV;
              end else begin
                gap_q <= gap_q + 8'h01;
              end
            end
          end
          default: state_q <= mission_logger_pkg::ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      mission_active <= 1'b0;
    end else begin
      mission_active <= !mission_stop && (state_q != mission_logger_pkg::ST_IDLE ||
                        (mission_start && !mission_arm_inhibit && sample_rate != 8'h00));
    end
  end

  // ----------------------------------------------------------------
  // Start timestamp and counters
  // ----------------------------------------------------------------
  // Time is latched on the same minute edge that requests the first sample
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      for (int i = 0; i < 5; i++) ts_q[i] <= 8'h00;
    end else if (memory_clear) begin
      for (int i = 0; i < 5; i++) ts_q[i] <= 8'h00;
    end else if (state_q == mission_logger_pkg::ST_DELAY && minute_tick &&
                 delay_q == 16'h0000 && !mission_stop) begin
      ts_q[0] <= rtc_minutes;
      ts_q[1] <= rtc_hours;
      ts_q[2] <= rtc_date;
      ts_q[3] <= rtc_month;
      ts_q[4] <= rtc_year;
    end
  end

  // Mission count; a sample in the clear cycle still counts from zero
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      mission_count_q <= mission_logger_pkg::COUNT_ZERO;
    end else if (sample_ev) begin
      mission_count_q <= memory_clear ? 24'h000001 : count_next;
    end else if (memory_clear) begin
      mission_count_q <= mission_logger_pkg::COUNT_ZERO;
    end
  end

  // Lifetime count has no clear path at all
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      lifetime_count_q <= mission_logger_pkg::COUNT_ZERO;
    end else if (sample_ev) begin
      lifetime_count_q <= lifetime_count_q + 24'h000001;
    end
  end

  // ----------------------------------------------------------------
  // Data log
  // ----------------------------------------------------------------
  // Pointer restarts at the base for each new mission
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      log_ptr_q <= 11'h000;
      log_full_q <= 1'b0;
    end else if (state_q == mission_logger_pkg::ST_IDLE && mission_start) begin
      log_ptr_q <= 11'h000;
      log_full_q <= 1'b0;
    end else if (sample_ev && !log_full_q) begin
      log_ptr_q <= log_ptr_q + 11'h001;
      if (!wrap_q && log_ptr_q == 11'(LOG_DEPTH - 1)) begin
        log_full_q <= 1'b1;
      end
    end
  end

  // Log array has no reset, like the memory it models
  always_ff @(posedge ref_clk) begin
    if (sample_ev && !log_full_q) begin
      log_mem[log_ptr_q] <= conv_data;
    end
  end

  // ----------------------------------------------------------------
  // Histogram
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      for (int i = 0; i < HIST_BINS; i++) hist_q[i] <= 16'h0000;
    end else if (memory_clear) begin
      for (int i = 0; i < HIST_BINS; i++) hist_q[i] <= 16'h0000;
    end else if (sample_ev && hist_q[bin] != mission_logger_pkg::BIN_MAX) begin
      hist_q[bin] <= hist_q[bin] + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Alarm flags and records
  // ----------------------------------------------------------------
  // Set beats clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      low_alarm_flag <= 1'b0;
      high_alarm_flag <= 1'b0;
    end else begin
      low_alarm_flag <= (sample_ev && out_low) || (low_alarm_flag && !low_flag_clear);
      high_alarm_flag <= (sample_ev && out_high) || (high_alarm_flag && !high_flag_clear);
    end
  end

  alarm_recorder #(.ENTRIES(mission_logger_pkg::ALARM_ENTRIES)) low_rec (
    .clk(ref_clk),
    .rst_n(rst_n_int),
    .clear(memory_clear),
    .sample_ev(sample_ev),
    .out_band(out_low),
    .count(count_next),
    .rd_idx(6'(rd_addr - mission_logger_pkg::ADDR_ALARM_BASE)),
    .rd_byte(low_byte)
  );

  alarm_recorder #(.ENTRIES(mission_logger_pkg::ALARM_ENTRIES)) high_rec (
    .clk(ref_clk),
    .rst_n(rst_n_int),
    .clear(memory_clear),
    .sample_ev(sample_ev),
    .out_band(out_high),
    .count(count_next),
    .rd_idx(6'(rd_addr - mission_logger_pkg::ADDR_HIGH_ALARM_BASE)),
    .rd_byte(high_byte)
  );

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // One cycle of latency; unmapped addresses read zero
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= 8'h00;
        if (rd_addr >= mission_logger_pkg::ADDR_LOG_BASE &&
            rd_addr <= mission_logger_pkg::ADDR_LOG_LAST) begin
          rd_data <= log_mem[11'(rd_addr - mission_logger_pkg::ADDR_LOG_BASE)];
        end else if (rd_addr >= mission_logger_pkg::ADDR_HIST_BASE &&
                     rd_addr <= mission_logger_pkg::ADDR_HIST_LAST) begin
          rd_data <= rd_addr[0] ? hist_q[rd_addr[6:1]][15:8] : hist_q[rd_addr[6:1]][7:0];
        end else if (rd_addr >= mission_logger_pkg::ADDR_HIGH_ALARM_BASE &&
                     rd_addr <= mission_logger_pkg::ADDR_ALARM_LAST) begin
          rd_data <= high_byte;
        end else if (rd_addr >= mission_logger_pkg::ADDR_ALARM_BASE &&
                     rd_addr < mission_logger_pkg::ADDR_HIGH_ALARM_BASE) begin
          rd_data <= low_byte;
        end else begin
          case (rd_addr)
            mission_logger_pkg::ADDR_START_MINUTES: rd_data <= ts_q[0];
            mission_logger_pkg::ADDR_START_HOURS: rd_data <= ts_q[1];
            mission_logger_pkg::ADDR_START_DATE: rd_data <= ts_q[2];
            mission_logger_pkg::ADDR_START_MONTH: rd_data <= ts_q[3];
            mission_logger_pkg::ADDR_START_YEAR: rd_data <= ts_q[4];
            mission_logger_pkg::ADDR_MISSION_COUNT_LOW: rd_data <= mission_count_q[7:0];
            mission_logger_pkg::ADDR_MISSION_COUNT_MID: rd_data <= mission_count_q[15:8];
            mission_logger_pkg::ADDR_MISSION_COUNT_HIGH: rd_data <= mission_count_q[23:16];
            mission_logger_pkg::ADDR_LIFETIME_COUNT_LOW: rd_data <= lifetime_count_q[7:0];
            mission_logger_pkg::ADDR_LIFETIME_COUNT_MID: rd_data <= lifetime_count_q[15:8];
            mission_logger_pkg::ADDR_LIFETIME_COUNT_HIGH: rd_data <= lifetime_count_q[23:16];
            default: rd_data <= 8'h00;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_int);

  sequence s_first_minute;
    state_q == mission_logger_pkg::ST_DELAY && delay_q == 16'h0000 && minute_tick &&
    !mission_stop;
  endsequence

  property p_first_stamp;
    s_first_minute |=> ts_q[0] == $past(rtc_minutes) && ts_q[4] == $past(rtc_year) &&
                      conv_request;
  endproperty
  a_first_stamp: assert property (p_first_stamp) else $error("start time not captured");

  property p_request_on_minute;
    conv_request |-> $past(minute_tick);
  endproperty
  a_request_on_minute: assert property (p_request_on_minute) else $error("request off minute");

  property p_count_step;
    sample_ev && !memory_clear |=> mission_count_q == $past(mission_count_q) + 24'h000001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("mission count not stepped");

  property p_count_clear;
    memory_clear && !sample_ev |=> mission_count_q == mission_logger_pkg::COUNT_ZERO;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("mission count not cleared");

  property p_lifetime_keep;
    !sample_ev |=> lifetime_count_q == $past(lifetime_count_q);
  endproperty
  a_lifetime_keep: assert property (p_lifetime_keep) else $error("lifetime count moved");

  property p_log_stop;
    log_full_q && sample_ev |=> log_ptr_q == $past(log_ptr_q) && log_full_q;
  endproperty
  a_log_stop: assert property (p_log_stop) else $error("log advanced when full");

  property p_hist_saturate;
    sample_ev && hist_q[bin] == mission_logger_pkg::BIN_MAX && !memory_clear
      |=> hist_q[$past(bin)] == mission_logger_pkg::BIN_MAX;
  endproperty
  a_hist_saturate: assert property (p_hist_saturate) else $error("bin wrapped");

  property p_hist_step;
    sample_ev && hist_q[bin] != mission_logger_pkg::BIN_MAX && !memory_clear
      |=> hist_q[$past(bin)] == $past(hist_q[bin]) + 16'h0001;
  endproperty
  a_hist_step: assert property (p_hist_step) else $error("bin not incremented");

  property p_high_flag;
    sample_ev && conv_data >= high_threshold |=> high_alarm_flag [*1] ##0 rd_valid == $past(rd_en);
  endproperty
  a_high_flag: assert property (p_high_flag) else $error("high flag not raised");

  property p_no_idle_hist;
    state_q == mission_logger_pkg::ST_IDLE && !memory_clear |=> hist_q[0] == $past(hist_q[0]);
  endproperty
  a_no_idle_hist: assert property (p_no_idle_hist) else $error("histogram moved idle");
endmodule // mission_temperature_logger

`default_nettype wire

// File: temp_source.sv
/*
  Behavioural model of the temperature converter facing the logger.
  Assumes requests are one-cycle pulses on ref_clk; answers after a set latency.
*/
`timescale 1ns/1ns
`default_nettype none
module temp_source (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Request and answer
  input wire logic conv_request,
  output logic conv_valid,
  output logic [7:0] conv_data,
  // Test controls
  input wire logic [7:0] reading,
  input wire logic [3:0] latency
);
  // ----------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------
  logic busy_q; // Conversion in progress
  logic [3:0] wait_q; // Cycles left before the result
  // Data toggles outside the answer cycle so a stale read never passes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      conv_valid <= 1'b0;
      conv_data <= 8'h00;
    end else begin
      conv_valid <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_request) begin
        busy_q <= 1'b1;
        wait_q <= latency;
      end else if (busy_q && wait_q == 4'h0) begin
        busy_q <= 1'b0;
        conv_valid <= 1'b1;
        conv_data <= reading;
      end else if (busy_q) begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule // temp_source
`default_nettype wire

// File: tb_top.sv
/*
  Self-checking bench of the mission logger: one mission, readback, clear, then two 2049-sample missions with and without wrap.
  Assumes the logger package and design files are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk, rst_n, mission_start, mission_stop, mission_arm_inhibit, log_wrap_enable;
  logic memory_clear, low_flag_clear, high_flag_clear, minute_tick, rd_en, rd_valid;
  logic conv_request, conv_valid, mission_active, low_alarm_flag, high_alarm_flag;
  logic [7:0] sample_rate, low_threshold, high_threshold, conv_data, rd_data, reading;
  logic [7:0] rtc_minutes, rtc_hours, rtc_date, rtc_month, rtc_year;
  logic [15:0] start_delay, rd_addr;
  logic [3:0] latency;
  int n_mismatch = 0;
  int num_checks = 0;
  // Expected memory after readings 40h, FFh, 05h
  logic [15:0] ad [17] = '{16'h0215, 16'h0216, 16'h0217, 16'h0218, 16'h0219, 16'h021a,
    16'h021b, 16'h021d, 16'h1000, 16'h1001, 16'h1002, 16'h0820, 16'h087c, 16'h0802,
    16'h0250, 16'h0253, 16'h0220};
  logic [7:0] ex [17] = '{8'h37, 8'h12, 8'h15, 8'h09, 8'h26, 8'h03, 8'h00, 8'h03, 8'h40,
    8'hff, 8'h05, 8'h01, 8'h01, 8'h01, 8'h02, 8'h01, 8'h03};
  // ----------------------------------------------------------------
  // Design and converter model
  // ----------------------------------------------------------------
  mission_temperature_logger dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .mission_start(mission_start), .mission_stop(mission_stop),
    .mission_arm_inhibit(mission_arm_inhibit), .sample_rate(sample_rate),
    .start_delay(start_delay), .log_wrap_enable(log_wrap_enable), .memory_clear(memory_clear),
    .low_threshold(low_threshold), .high_threshold(high_threshold),
    .low_flag_clear(low_flag_clear), .high_flag_clear(high_flag_clear),
    .minute_tick(minute_tick), .rtc_minutes(rtc_minutes), .rtc_hours(rtc_hours),
    .rtc_date(rtc_date), .rtc_month(rtc_month), .rtc_year(rtc_year),
    .conv_request(conv_request), .conv_valid(conv_valid), .conv_data(conv_data),
    .mission_active(mission_active), .low_alarm_flag(low_alarm_flag),
    .high_alarm_flag(high_alarm_flag), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_valid(rd_valid), .rd_data(rd_data));
  temp_source src_u (.ref_clk(ref_clk), .rst_n(rst_n), .conv_request(conv_request),
    .conv_valid(conv_valid), .conv_data(conv_data), .reading(reading), .latency(latency));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read answers one cycle later, looked at before the next edge
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge ref_clk) rd_en = 1'b1;
    rd_addr = a;
    @(negedge ref_clk) rd_en = 1'b0;
    chk({7'h0, rd_valid}, 8'h01);
    chk(rd_data, e);
  endtask
  // One minute boundary, then a bounded wait for the converter answer
  task automatic take(input logic [7:0] v);
    int i;
    reading = v;
    @(negedge ref_clk) minute_tick = 1'b1;
    @(negedge ref_clk) minute_tick = 1'b0;
    for (i = 0; i < 30 && !conv_valid; i++) @(negedge ref_clk);
    if (i == 30) begin
      n_mismatch++;
      summarize();
    end
    repeat (2) @(negedge ref_clk);
  endtask
  // In band, high with slow answer, then low with prompt answer
  task automatic mission_run;
    @(negedge ref_clk) mission_start = 1'b1;
    @(negedge ref_clk) mission_start = 1'b0;
    chk({7'h0, mission_active}, 8'h01);
    take(8'h40);
    latency = 4'h9;
    take(8'hff);
    latency = 4'h0;
    take(8'h05);
    chk({7'h0, high_alarm_flag}, 8'h01);
    chk({7'h0, low_alarm_flag}, 8'h01);
    foreach (ad[k]) rd(ad[k], ex[k]);
  endtask
  // Clear zeroes mission count and bins, lifetime survives
  task automatic clear_run;
    @(negedge ref_clk) memory_clear = 1'b1;
    @(negedge ref_clk) memory_clear = 1'b0;
    rd(16'h021a, 8'h00);
    rd(16'h021d, 8'h03);
    rd(16'h087c, 8'h00);
    rd(16'h0400, 8'h00);
    // Flag clears and stop, then a start refused while inhibited
    @(negedge ref_clk) {low_flag_clear, high_flag_clear, mission_stop} = 3'b111;
    @(negedge ref_clk) {low_flag_clear, high_flag_clear, mission_stop} = 3'b000;
    chk({6'h0, low_alarm_flag, high_alarm_flag}, 8'h00);
    chk({7'h0, mission_active}, 8'h00);
    @(negedge ref_clk) {mission_arm_inhibit, mission_start} = 2'b11;
    @(negedge ref_clk) {mission_arm_inhibit, mission_start} = 2'b00;
    chk({7'h0, mission_active}, 8'h00);
  endtask
  // 2049 samples: slot 0 is overwritten only with wrap; long high episode splits at 255
  task automatic long_run(input logic w, input logic [7:0] e0);
    @(negedge ref_clk) mission_stop = 1'b1;
    memory_clear = 1'b1;
    log_wrap_enable = w;
    @(negedge ref_clk) {mission_stop, memory_clear, mission_start} = 3'b001;
    @(negedge ref_clk) mission_start = 1'b0;
    latency = 4'h0;
    take(8'h10);
    repeat (2047) take(8'hff);
    take(8'h40);
    rd(16'h1000, e0);
    rd(16'h1001, 8'hff);
    rd(16'h021a, 8'h01);
    rd(16'h021b, 8'h08);
    rd(16'h087d, 8'h07);
    rd(16'h0253, 8'hff);
    rd(16'h0255, 8'h01);
    rd(16'h0273, 8'h07);
  endtask
  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    {rst_n, mission_start, mission_stop, mission_arm_inhibit, log_wrap_enable} = 5'h00;
    {memory_clear, low_flag_clear, high_flag_clear, minute_tick, rd_en} = 5'h00;
    sample_rate = 8'h01;
    start_delay = 16'h0000;
    low_threshold = 8'h08;
    high_threshold = 8'hf0;
    {rtc_minutes, rtc_hours, rtc_date, rtc_month, rtc_year} = 40'h3712150926;
    rd_addr = 16'h0000;
    reading = 8'h00;
    latency = 4'h2;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    mission_run();
    clear_run();
    long_run(1'b1, 8'h40);
    long_run(1'b0, 8'h10);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
